// ### logic/srap_pkg.sv
package srap_pkg;

  // fixed upper part of the seven-bit bus address
  localparam logic [4:0] BASE_ADDR_HI     = 5'h1b;
  // register indices
  localparam logic [7:0] REG_SOFT_RESET   = 8'h00;
  localparam logic [7:0] REG_BUS_ADDR     = 8'h01;
  localparam logic [7:0] REG_FIRST_RELOAD = 8'h02;
  localparam logic [7:0] REG_LEVEL_SEL    = 8'h1f;
  // field positions
  localparam int         SOFT_RESET_BIT   = 0;
  localparam int         LEVEL_SEL_BIT    = 0;
  // values after reset and writable masks
  localparam logic [7:0] LEVEL_SEL_RESET  = 8'h01;
  localparam logic [7:0] GENERIC_RESET    = 8'h00;
  localparam logic [7:0] LEVEL_SEL_MASK   = 8'h01;
  localparam logic [7:0] FULL_MASK        = 8'hff;
  // backed register space, indices at or above read zero
  localparam int         IDX_W            = 6;
  localparam int         REG_DEPTH        = 64;
  // bits of a byte, then the acknowledge slot
  localparam logic [3:0] BITS_PER_BYTE    = 4'h8;
  // serial clock timing, fastest legal rate 400 kHz
  localparam int         CLK_PERIOD_NS    = 8;
  localparam int         SCL_MIN_PERIOD_NS = 2500;
  localparam int         SCL_QTR_CYC      =
    (SCL_MIN_PERIOD_NS + 4 * CLK_PERIOD_NS - 1) / (4 * CLK_PERIOD_NS);
  localparam logic [6:0] SCL_QTR_LAST     = 7'(SCL_QTR_CYC - 1);

endpackage : srap_pkg

// ### logic/srap_link_if.sv
interface srap_link_if;

  logic scl;
  logic host_sda_out;
  logic host_sda_oe;
  logic dev_sda_out;
  logic dev_sda_oe;
  logic sda;

  // open-drain data line with pull-up: low while any driver pulls low
  assign sda = ~((host_sda_oe & ~host_sda_out) |
                 (dev_sda_oe & ~dev_sda_out));

  modport host (output scl, output host_sda_out, output host_sda_oe,
                input sda);
  modport device (input scl, input sda, output dev_sda_out,
                  output dev_sda_oe);

endinterface : srap_link_if

// ### logic/srap_device_end.sv
//////////////////////////////////////////////////////////////////////////////
module srap_device_end (
  input  wire logic       ref_clk_in,
  input  wire logic       reset_n_in,
  input  wire logic       clk_en_in,
  input  wire logic [1:0] addr_strap_in,
  output logic            status_pin_level_select_out,
  output logic            wr_strobe_out,
  output logic [7:0]      wr_index_out,
  output logic [7:0]      wr_data_out,
  srap_link_if.device     link
);

  typedef enum logic [3:0] {
    D_IDLE, D_ADDR, D_ADDR_ACK, D_INDEX, D_INDEX_ACK,
    D_WDATA, D_WDATA_ACK, D_RDATA, D_RDATA_ACK, D_IGNORE
  } srap_dev_state_t;

  srap_dev_state_t state_ff;
  srap_dev_state_t nxt_state;
  logic [1:0]      scl_sync_ff;
  logic [1:0]      sda_sync_ff;
  logic [1:0]      strap_a_ff;
  logic [1:0]      strap_b_ff;
  logic            scl_prev_ff;
  logic            sda_prev_ff;
  logic [7:0]      sh_ff;
  logic [7:0]      nxt_sh;
  logic [3:0]      cnt_ff;
  logic [3:0]      nxt_cnt;
  logic [7:0]      idx_ff;
  logic [7:0]      nxt_idx;
  logic            oe_ff;
  logic            nxt_oe;
  logic            rw_ff;
  logic            nxt_rw;
  logic            mack_ff;
  logic            nxt_mack;
  logic            wr_strobe_ff;
  logic            nxt_wr_strobe;
  logic [7:0]      wr_index_ff;
  logic [7:0]      nxt_wr_index;
  logic [7:0]      wr_data_ff;
  logic [7:0]      nxt_wr_data;
  logic            level_ff;
  logic [7:0]      regs_ff [0:srap_pkg::REG_DEPTH-1];
  logic [7:0]      nxt_regs [0:srap_pkg::REG_DEPTH-1];
  logic            scl_s;
  logic            sda_s;
  logic            start_c;
  logic            stop_c;
  logic            rise_c;
  logic            fall_c;
  logic [7:0]      rd_byte;

  // value a backed register takes at reset and soft reset
  function automatic logic [7:0] reg_default(input logic [7:0] idx);
    reg_default = (idx == srap_pkg::REG_LEVEL_SEL) ?
                  srap_pkg::LEVEL_SEL_RESET : srap_pkg::GENERIC_RESET;
  endfunction : reg_default

  //////////////////////////////////////////////////////////////////////////
  // pin synchronisers; the strap is sampled only after reset release
  always_ff @(posedge ref_clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      scl_sync_ff <= 2'h3;
      sda_sync_ff <= 2'h3;
      strap_a_ff  <= 2'h0;
      strap_b_ff  <= 2'h0;
      scl_prev_ff <= 1'b1;
      sda_prev_ff <= 1'b1;
    end
    else if (clk_en_in)
    begin
      scl_sync_ff <= {scl_sync_ff[0], link.scl};
      sda_sync_ff <= {sda_sync_ff[0], link.sda};
      strap_a_ff  <= addr_strap_in;
      strap_b_ff  <= strap_a_ff;
      scl_prev_ff <= scl_sync_ff[1];
      sda_prev_ff <= sda_sync_ff[1];
    end
  end

  // bus events; clock is never stretched, the master paces it
  assign scl_s   = scl_sync_ff[1];
  assign sda_s   = sda_sync_ff[1];
  assign start_c = scl_s & scl_prev_ff & sda_prev_ff & ~sda_s;
  assign stop_c  = scl_s & scl_prev_ff & ~sda_prev_ff & sda_s;
  assign rise_c  = scl_s & ~scl_prev_ff;
  assign fall_c  = ~scl_s & scl_prev_ff;

  //////////////////////////////////////////////////////////////////////////
  // read view of the register at the current index
  always_comb
  begin
    rd_byte = 8'h00;
    if (idx_ff == srap_pkg::REG_BUS_ADDR)
      rd_byte = {1'b0, srap_pkg::BASE_ADDR_HI, strap_b_ff};
    else if (idx_ff != srap_pkg::REG_SOFT_RESET &&
             idx_ff[7:srap_pkg::IDX_W] == '0)
      rd_byte = regs_ff[idx_ff[srap_pkg::IDX_W-1:0]];
    // soft reset bit is never stored, so it reads zero
  end

  //////////////////////////////////////////////////////////////////////////
  // serial engine and register writes
  always_comb
  begin
    nxt_state     = state_ff;
    nxt_sh        = sh_ff;
    nxt_cnt       = cnt_ff;
    nxt_idx       = idx_ff;
    nxt_oe        = oe_ff;
    nxt_rw        = rw_ff;
    nxt_mack      = mack_ff;
    nxt_wr_strobe = 1'b0;
    nxt_wr_index  = wr_index_ff;
    nxt_wr_data   = wr_data_ff;
    nxt_regs      = regs_ff;
    if (start_c)
    begin
      // repeated start keeps the index for the read phase
      nxt_state = D_ADDR;
      nxt_cnt   = 4'h0;
      nxt_oe    = 1'b0;
    end
    else if (stop_c)
    begin
      // stop after any whole byte simply ends the transfer
      nxt_state = D_IDLE;
      nxt_oe    = 1'b0;
    end
    else
    begin
      unique case (state_ff)
        D_ADDR, D_INDEX, D_WDATA:
        begin
          if (rise_c)
          begin
            nxt_sh  = {sh_ff[6:0], sda_s};
            nxt_cnt = cnt_ff + 4'h1;
          end
          else if (fall_c && cnt_ff == srap_pkg::BITS_PER_BYTE)
          begin
            nxt_cnt = 4'h0;
            nxt_oe  = 1'b1;
            if (state_ff == D_ADDR)
            begin
              if (sh_ff[7:1] == {srap_pkg::BASE_ADDR_HI, strap_b_ff})
              begin
                nxt_rw    = sh_ff[0];
                nxt_state = D_ADDR_ACK;
              end
              else
              begin
                nxt_oe    = 1'b0;
                nxt_state = D_IGNORE;
              end
            end
            else if (state_ff == D_INDEX)
            begin
              nxt_idx   = sh_ff;
              nxt_state = D_INDEX_ACK;
            end
            else
            begin
              // commit now, not at stop
              nxt_wr_strobe = 1'b1;
              nxt_wr_index  = idx_ff;
              nxt_wr_data   = sh_ff;
              if (idx_ff == srap_pkg::REG_SOFT_RESET)
              begin
                if (sh_ff[srap_pkg::SOFT_RESET_BIT])
                begin
                  // engine state and 0x00/0x01 untouched
                  for (int i = int'(srap_pkg::REG_FIRST_RELOAD);
                       i < srap_pkg::REG_DEPTH; i++)
                    nxt_regs[i] = reg_default(8'(i));
                end
              end
              else if (idx_ff != srap_pkg::REG_BUS_ADDR &&
                       idx_ff[7:srap_pkg::IDX_W] == '0)
              begin
                // reserved bits of the level register stay zero
                nxt_regs[idx_ff[srap_pkg::IDX_W-1:0]] = sh_ff &
                  ((idx_ff == srap_pkg::REG_LEVEL_SEL) ?
                   srap_pkg::LEVEL_SEL_MASK : srap_pkg::FULL_MASK);
              end
              nxt_idx   = idx_ff + 8'h01;
              nxt_state = D_WDATA_ACK;
            end
          end
        end
        D_ADDR_ACK, D_INDEX_ACK, D_WDATA_ACK:
        begin
          if (fall_c)
          begin
            if (state_ff == D_ADDR_ACK && rw_ff)
            begin
              nxt_sh    = rd_byte;
              nxt_oe    = ~rd_byte[7];
              nxt_state = D_RDATA;
            end
            else
            begin
              nxt_oe    = 1'b0;
              nxt_state = (state_ff == D_ADDR_ACK) ? D_INDEX : D_WDATA;
            end
          end
        end
        D_RDATA:
        begin
          if (rise_c)
            nxt_cnt = cnt_ff + 4'h1;
          else if (fall_c)
          begin
            if (cnt_ff == srap_pkg::BITS_PER_BYTE)
            begin
              nxt_cnt   = 4'h0;
              nxt_oe    = 1'b0;
              nxt_idx   = idx_ff + 8'h01;
              nxt_state = D_RDATA_ACK;
            end
            else
            begin
              nxt_sh = {sh_ff[6:0], 1'b0};
              nxt_oe = ~sh_ff[6];
            end
          end
        end
        D_RDATA_ACK:
        begin
          if (rise_c)
            nxt_mack = ~sda_s;
          else if (fall_c)
          begin
            // a missing acknowledge ends sending until the next start or stop
            if (mack_ff)
            begin
              nxt_sh    = rd_byte;
              nxt_oe    = ~rd_byte[7];
              nxt_state = D_RDATA;
            end
            else
              nxt_state = D_IGNORE;
          end
        end
        D_IDLE, D_IGNORE:
        begin
          nxt_oe = 1'b0;
        end
      endcase
    end
  end

  // engine registers, the level flop and the register array live here; array reset is constant per index
  always_ff @(posedge ref_clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      state_ff     <= D_IDLE;
      sh_ff        <= 8'h00;
      cnt_ff       <= 4'h0;
      idx_ff       <= 8'h00;
      oe_ff        <= 1'b0;
      rw_ff        <= 1'b0;
      mack_ff      <= 1'b0;
      wr_strobe_ff <= 1'b0;
      wr_index_ff  <= 8'h00;
      wr_data_ff   <= 8'h00;
      level_ff     <= srap_pkg::LEVEL_SEL_RESET[srap_pkg::LEVEL_SEL_BIT];
      for (int i = 0; i < srap_pkg::REG_DEPTH; i++)
        regs_ff[i] <= reg_default(8'(i));
    end
    else if (clk_en_in)
    begin
      state_ff     <= nxt_state;
      sh_ff        <= nxt_sh;
      cnt_ff       <= nxt_cnt;
      idx_ff       <= nxt_idx;
      oe_ff        <= nxt_oe;
      rw_ff        <= nxt_rw;
      mack_ff      <= nxt_mack;
      wr_strobe_ff <= nxt_wr_strobe;
      wr_index_ff  <= nxt_wr_index;
      wr_data_ff   <= nxt_wr_data;
      level_ff     <= nxt_regs[srap_pkg::REG_LEVEL_SEL[srap_pkg::IDX_W-1:0]]
                      [srap_pkg::LEVEL_SEL_BIT];
      regs_ff      <= nxt_regs;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // outputs; the line is only ever pulled low
  assign link.dev_sda_out            = 1'b0;
  assign link.dev_sda_oe             = oe_ff;
  assign status_pin_level_select_out = level_ff;
  assign wr_strobe_out               = wr_strobe_ff;
  assign wr_index_out                = wr_index_ff;
  assign wr_data_out                 = wr_data_ff;

endmodule : srap_device_end

// ### logic/srap_host_end.sv
module srap_host_end (
  input  wire logic       ref_clk_in,
  input  wire logic       reset_n_in,
  input  wire logic       clk_en_in,
  input  wire logic       cmd_valid_in,
  input  wire logic       cmd_read_in,
  input  wire logic [6:0] cmd_dev_addr_in,
  input  wire logic [7:0] cmd_index_in,
  input  wire logic [7:0] cmd_len_in,
  input  wire logic [7:0] wr_data_in,
  output logic            cmd_ready_out,
  output logic            wr_next_out,
  output logic [7:0]      rd_data_out,
  output logic            rd_valid_out,
  output logic            nack_out,
  srap_link_if.host       link
);

  typedef enum logic [1:0] {H_IDLE, H_START, H_BIT, H_STOP} srap_host_state_t;
  typedef enum logic [2:0] {
    P_ADDR_W, P_INDEX, P_WDATA, P_ADDR_R, P_RDATA
  } srap_host_phase_t;

  srap_host_state_t state_ff, nxt_state;
  srap_host_phase_t phase_ff, nxt_phase;
  logic [1:0]       sda_sync_ff;
  logic [6:0]       div_ff, nxt_div;
  logic [1:0]       q_ff, nxt_q;
  logic [3:0]       bit_ff, nxt_bit;
  logic [7:0]       sh_ff, nxt_sh;
  logic [7:0]       len_ff, nxt_len;
  logic [7:0]       idx_ff, nxt_idx;
  logic [6:0]       dev_ff, nxt_dev;
  logic             rd_ff, nxt_rd;
  logic             ack_ff, nxt_ack;
  logic             scl_ff, nxt_scl;
  logic             oe_ff, nxt_oe;
  logic             ready_ff, nxt_ready;
  logic             wnext_ff, nxt_wnext;
  logic [7:0]       rdata_ff, nxt_rdata;
  logic             rvalid_ff, nxt_rvalid;
  logic             nack_ff, nxt_nack;
  logic             tick;
  logic             rx;

  // the data line is read back only through two flops
  always_ff @(posedge ref_clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
      sda_sync_ff <= 2'h3;
    else if (clk_en_in)
      sda_sync_ff <= {sda_sync_ff[0], link.sda};
  end

  // quarter-period tick keeps the clock at or under 400 kHz
  assign tick = (div_ff == srap_pkg::SCL_QTR_LAST);
  assign rx   = (phase_ff == P_RDATA);

  //////////////////////////////////////////////////////////////////////////
  // bit sequencer: q0 set data, q1 clock high, q2 sample, q3 clock low
  always_comb
  begin
    nxt_state  = state_ff;
    nxt_phase  = phase_ff;
    nxt_div    = (state_ff == H_IDLE || tick) ? 7'h00 : div_ff + 7'h01;
    nxt_q      = q_ff;
    nxt_bit    = bit_ff;
    nxt_sh     = sh_ff;
    nxt_len    = len_ff;
    nxt_idx    = idx_ff;
    nxt_dev    = dev_ff;
    nxt_rd     = rd_ff;
    nxt_ack    = ack_ff;
    nxt_scl    = scl_ff;
    nxt_oe     = oe_ff;
    nxt_ready  = ready_ff;
    nxt_wnext  = 1'b0;
    nxt_rdata  = rdata_ff;
    nxt_rvalid = 1'b0;
    nxt_nack   = nack_ff;
    if (state_ff == H_IDLE)
    begin
      if (cmd_valid_in)
      begin
        nxt_state = H_START;
        nxt_phase = P_ADDR_W;
        nxt_q     = 2'h0;
        nxt_sh    = {cmd_dev_addr_in, 1'b0};
        nxt_dev   = cmd_dev_addr_in;
        nxt_idx   = cmd_index_in;
        nxt_rd    = cmd_read_in;
        nxt_len   = (cmd_read_in && cmd_len_in == 8'h00) ? 8'h01
                                                         : cmd_len_in;
        nxt_ready = 1'b0;
        nxt_nack  = 1'b0;
      end
    end
    else if (tick)
    begin
      nxt_q = q_ff + 2'h1;
      unique case (state_ff)
        H_START:
        begin
          unique case (q_ff)
            2'h0: nxt_oe = 1'b0;
            2'h1: nxt_scl = 1'b1;
            2'h2: nxt_oe = 1'b1;
            2'h3:
            begin
              nxt_scl   = 1'b0;
              nxt_bit   = 4'h0;
              nxt_state = H_BIT;
            end
          endcase
        end
        H_STOP:
        begin
          unique case (q_ff)
            2'h0: nxt_oe = 1'b1;
            2'h1: nxt_scl = 1'b1;
            2'h2: nxt_oe = 1'b0;
            2'h3:
            begin
              nxt_state = H_IDLE;
              nxt_ready = 1'b1;
            end
          endcase
        end
        H_BIT:
        begin
          unique case (q_ff)
            2'h0: nxt_oe = (bit_ff != srap_pkg::BITS_PER_BYTE) ?
                           (~rx & ~sh_ff[7]) : (rx & (len_ff != 8'h01));
            2'h1: nxt_scl = 1'b1;
            2'h2:
            begin
              if (bit_ff != srap_pkg::BITS_PER_BYTE)
                nxt_sh = {sh_ff[6:0], sda_sync_ff[1]};
              else
                nxt_ack = ~sda_sync_ff[1];
            end
            2'h3:
            begin
              nxt_scl = 1'b0;
              nxt_bit = bit_ff + 4'h1;
              if (bit_ff == srap_pkg::BITS_PER_BYTE)
              begin
                nxt_bit = 4'h0;
                if (!rx && !ack_ff)
                begin
                  nxt_nack  = 1'b1;
                  nxt_state = H_STOP;
                end
                else
                begin
                  unique case (phase_ff)
                    P_ADDR_W:
                    begin
                      nxt_phase = P_INDEX;
                      nxt_sh    = idx_ff;
                    end
                    P_INDEX:
                    begin
                      if (rd_ff)
                      begin
                        // turn round with a repeated start
                        nxt_phase = P_ADDR_R;
                        nxt_sh    = {dev_ff, 1'b1};
                        nxt_state = H_START;
                      end
                      else if (len_ff == 8'h00)
                        nxt_state = H_STOP;
                      else
                      begin
                        nxt_phase = P_WDATA;
                        nxt_sh    = wr_data_in;
                        nxt_wnext = 1'b1;
                      end
                    end
                    P_WDATA:
                    begin
                      nxt_len = len_ff - 8'h01;
                      if (len_ff == 8'h01)
                        nxt_state = H_STOP;
                      else
                      begin
                        nxt_sh    = wr_data_in;
                        nxt_wnext = 1'b1;
                      end
                    end
                    P_ADDR_R: nxt_phase = P_RDATA;
                    P_RDATA:
                    begin
                      nxt_rdata  = sh_ff;
                      nxt_rvalid = 1'b1;
                      nxt_len    = len_ff - 8'h01;
                      if (len_ff == 8'h01)
                        nxt_state = H_STOP;
                    end
                    default: nxt_state = H_STOP;
                  endcase
                end
              end
            end
          endcase
        end
        default: nxt_state = H_IDLE;
      endcase
    end
  end

  always_ff @(posedge ref_clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      state_ff  <= H_IDLE;
      phase_ff  <= P_ADDR_W;
      div_ff    <= 7'h00;
      q_ff      <= 2'h0;
      bit_ff    <= 4'h0;
      sh_ff     <= 8'h00;
      len_ff    <= 8'h00;
      idx_ff    <= 8'h00;
      dev_ff    <= 7'h00;
      rd_ff     <= 1'b0;
      ack_ff    <= 1'b0;
      scl_ff    <= 1'b1;
      oe_ff     <= 1'b0;
      ready_ff  <= 1'b1;
      wnext_ff  <= 1'b0;
      rdata_ff  <= 8'h00;
      rvalid_ff <= 1'b0;
      nack_ff   <= 1'b0;
    end
    else if (clk_en_in)
    begin
      state_ff  <= nxt_state;
      phase_ff  <= nxt_phase;
      div_ff    <= nxt_div;
      q_ff      <= nxt_q;
      bit_ff    <= nxt_bit;
      sh_ff     <= nxt_sh;
      len_ff    <= nxt_len;
      idx_ff    <= nxt_idx;
      dev_ff    <= nxt_dev;
      rd_ff     <= nxt_rd;
      ack_ff    <= nxt_ack;
      scl_ff    <= nxt_scl;
      oe_ff     <= nxt_oe;
      ready_ff  <= nxt_ready;
      wnext_ff  <= nxt_wnext;
      rdata_ff  <= nxt_rdata;
      rvalid_ff <= nxt_rvalid;
      nack_ff   <= nxt_nack;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // clock is driven push-pull, data open-drain
  assign link.scl          = scl_ff;
  assign link.host_sda_out = 1'b0;
  assign link.host_sda_oe  = oe_ff;
  assign cmd_ready_out     = ready_ff;
  assign wr_next_out       = wnext_ff;
  assign rd_data_out       = rdata_ff;
  assign rd_valid_out      = rvalid_ff;
  assign nack_out          = nack_ff;

endmodule : srap_host_end

// ### tb/srap_link_chk.sv
module srap_link_chk (
  input wire logic ref_clk_in,
  input wire logic reset_n_in,
  input wire logic scl,
  input wire logic sda,
  input wire logic host_sda_oe,
  input wire logic dev_sda_oe
);
  default clocking dc @(posedge ref_clk_in); endclocking
  default disable iff (!reset_n_in);
  logic       scl_q_ff;
  logic       sda_q_ff;
  logic [8:0] per_ff;
  logic [3:0] bit_ff;
  logic [7:0] frm_ff;
  ////////////////////////////////////////////////////////////////////////////
  // bit and frame position since the last start; period count saturates
  always_ff @(posedge ref_clk_in or negedge reset_n_in)
    if (!reset_n_in)
      {scl_q_ff, sda_q_ff, per_ff, bit_ff, frm_ff} <= {11'h7ff, 12'h000};
    else
    begin
      scl_q_ff <= scl;
      sda_q_ff <= sda;
      per_ff   <= (scl && !scl_q_ff) ? 9'h000 : per_ff + 9'(per_ff != '1);
      if (scl && scl_q_ff && sda_q_ff && !sda)
        {bit_ff, frm_ff} <= 12'h000;
      else if (scl && !scl_q_ff)
        {bit_ff, frm_ff} <= (bit_ff == 4'h9) ? {4'h1, frm_ff + 8'h01}
                                             : {bit_ff + 4'h1, frm_ff};
    end
  ////////////////////////////////////////////////////////////////////////////
  // start and stop: data line moves while the clock stays high
  sequence start_s;
    scl && scl_q_ff && $fell(sda);
  endsequence
  sequence stop_s;
    scl && scl_q_ff && $rose(sda);
  endsequence
  scl_period_a:
    assert property ($rose(scl) |-> per_ff >= 9'h12c)
    else $error("serial clock period too short");
  start_host_a:
    assert property (start_s |-> host_sda_oe && !dev_sda_oe)
    else $error("start not made by the host");
  start_hold_a:
    assert property (start_s |-> scl [*8])
    else $error("clock fell right after start");
  stop_idle_a:
    assert property (stop_s |-> (scl && !dev_sda_oe) [*8])
    else $error("line not idle after stop");
  // the device may only move data while the clock is low
  dev_steady_a:
    assert property ($changed(dev_sda_oe) |-> !scl)
    else $error("device changed data with clock high");
  addr_quiet_a:
    assert property (scl && scl_q_ff && frm_ff == 0 && bit_ff != 4'h9
                     |-> !dev_sda_oe)
    else $error("device drove during address bits");
  host_ack_a:
    assert property (scl && scl_q_ff && frm_ff == 0 && bit_ff == 4'h9
                     |-> !host_sda_oe)
    else $error("host drove the address ack slot");
  reset_idle_a:
    assert property (!$past(reset_n_in) |-> scl && !host_sda_oe && !dev_sda_oe)
    else $error("link not idle after reset");
endmodule : srap_link_chk

// ### tb/srap_tb_top.sv
module srap_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        ref_clk_in = 1'b0;
  logic        reset_n_in = 1'b0;
  logic        cmd_valid_in = 1'b0;
  logic        cmd_read_in = 1'b0;
  logic [6:0]  cmd_dev_addr_in = 7'h00;
  logic [7:0]  cmd_index_in = 8'h00;
  logic [7:0]  cmd_len_in = 8'h00;
  logic [7:0]  wr_data_in = 8'h00;
  logic [1:0]  addr_strap_in = 2'b00;
  logic        cmd_ready_out, wr_next_out, rd_valid_out, nack_out;
  logic        status_pin_level_select_out, wr_strobe_out;
  logic [7:0]  rd_data_out, wr_index_out, wr_data_out;
  logic [7:0]  mdl [64];
  logic [15:0] wq [$];
  logic [7:0]  rq [$], dq [$];
  logic [15:0] exp_v;
  integer      seed = 32'hb8cc_f090;
  int          error_cnt = 0, checks = 0, cyc = 0;
  wire  [6:0]  own = {srap_pkg::BASE_ADDR_HI, addr_strap_in};
  ////////////////////////////////////////////////////////////////////////////
  srap_link_if srap_link_if_i ();
  srap_host_end srap_host_end_i (.ref_clk_in, .reset_n_in, .clk_en_in (1'b1),
    .cmd_valid_in, .cmd_read_in, .cmd_dev_addr_in, .cmd_index_in,
    .cmd_len_in, .wr_data_in, .cmd_ready_out, .wr_next_out, .rd_data_out,
    .rd_valid_out, .nack_out, .link (srap_link_if_i));
  srap_device_end srap_device_end_i (.ref_clk_in, .reset_n_in,
    .clk_en_in (1'b1), .addr_strap_in, .status_pin_level_select_out,
    .wr_strobe_out, .wr_index_out, .wr_data_out, .link (srap_link_if_i));
  srap_link_chk srap_link_chk_i (.ref_clk_in, .reset_n_in,
    .scl (srap_link_if_i.scl), .sda (srap_link_if_i.sda),
    .host_sda_oe (srap_link_if_i.host_sda_oe),
    .dev_sda_oe (srap_link_if_i.dev_sda_oe));
  ////////////////////////////////////////////////////////////////////////////
  // 125 MHz
  always #4 ref_clk_in = ~ref_clk_in;
  task close_out;
    $display("errors %0d checks %0d", error_cnt, checks);
    if (error_cnt == 0 && checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : close_out
  task chk(input string n, input logic [15:0] e, input logic [15:0] s);
    checks++;
    if (s !== e)
    begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  // register model; soft reset doubles as the power-up defaults
  task wrm(input logic [7:0] i, input logic [7:0] d);
    if (i == 8'h00 && d[0])
      for (int k = 2; k < 64; k++)
        mdl[k] = (k == 31) ? 8'h01 : 8'h00;
    else if (i == 8'h1f)
      mdl[31] = {7'h00, d[0]};
    else if (i > 8'h01 && i < 8'h40)
      mdl[i[5:0]] = d;
  endtask : wrm
  function automatic logic [7:0] rdm(input logic [7:0] i);
    if (i == 8'h01)
      return {1'b0, own};
    return (i == 8'h00 || i > 8'h3f) ? 8'h00 : mdl[i[5:0]];
  endfunction : rdm
  // one command; expectations are queued before the line moves
  task xfer(input logic r, input logic [6:0] a, input logic [7:0] i,
            input logic [7:0] n, input logic [7:0] o);
    logic [7:0] d;
    for (int k = 0; k < n; k++)
    begin
      d = 8'($random(seed)) | o;
      if (r && a == own)
        rq.push_back(rdm(i + 8'(k)));
      if (!r)
        dq.push_back(d);
      if (!r && a == own)
      begin
        wq.push_back({i + 8'(k), d});
        wrm(i + 8'(k), d);
      end
    end
    @(negedge ref_clk_in);
    {cmd_valid_in, cmd_read_in, cmd_dev_addr_in} = {1'b1, r, a};
    {cmd_index_in, cmd_len_in} = {i, n};
    wr_data_in = dq.size() ? dq.pop_front() : 8'h00;
    @(negedge ref_clk_in);
    cmd_valid_in = 1'b0;
    repeat (3) @(negedge ref_clk_in);
    repeat (40000)
    begin
      if (cmd_ready_out === 1'b1)
        break;
      if (wr_next_out === 1'b1)
        wr_data_in = dq.size() ? dq.pop_front() : 8'h00;
      @(negedge ref_clk_in);
    end
    dq.delete();
    chk("ready", 16'h0001, 16'(cmd_ready_out));
    chk("nack", 16'(a != own), 16'(nack_out));
    chk("left", 16'h0000, 16'(wq.size() + rq.size()));
    chk("idle", 16'h0003, 16'({srap_link_if_i.scl, srap_link_if_i.sda}));
    chk("lvl", 16'(mdl[31][0]), 16'(status_pin_level_select_out));
  endtask : xfer
  ////////////////////////////////////////////////////////////////////////////
  // every strobe and read byte against the model; hang guard
  // sampled mid-cycle so flop outputs have settled
  always @(negedge ref_clk_in)
  begin
    cyc++;
    if (cyc == 95000)
    begin
      error_cnt++;
      close_out();
    end
    if (wr_strobe_out === 1'b1)
    begin
      exp_v = wq.size() ? wq.pop_front() : 'x;
      chk("wr", exp_v, {wr_index_out, wr_data_out});
    end
    if (rd_valid_out === 1'b1)
    begin
      exp_v = rq.size() ? 16'(rq.pop_front()) : 'x;
      chk("rd", exp_v, 16'(rd_data_out));
    end
  end
  initial
  begin
    addr_strap_in = 2'($random(seed));
    wrm(8'h00, 8'h01);
    repeat (10) @(negedge ref_clk_in);
    reset_n_in = 1'b1;
    repeat (4) @(negedge ref_clk_in);
    xfer(1'b1, own, 8'h00, 8'h02, 8'h00);
    xfer(1'b0, own, 8'h1e, 8'h03, 8'h00);
    xfer(1'b0, own ^ 7'h01, 8'h1e, 8'h01, 8'h00);
    xfer(1'b1, own, 8'h1e, 8'h03, 8'h00);
    xfer(1'b0, own, 8'h00, 8'h01, 8'h01);
    xfer(1'b1, own, 8'h1e, 8'h03, 8'h00);
    close_out();
  end
endmodule : srap_tb_top
